// [hw/plc_pkg.sv]
// constants, register map and types for the logic array power and reset control
package plc_pkg;

   localparam int CLK_PERIOD_NS = 4;
   // speed grade select: 0 for the fast grade, 1 for the slow grade
   localparam bit SLOW_GRADE = 1'b0;

   localparam int MAC_W = 10;
   localparam int IN_W  = 11;
   localparam int ARR_W = 12;
   localparam int CTL_W = 4;
   localparam int CNT_W = 8;
   localparam int SIG_W = 32;

   // times in ns
   localparam int POWERUP_RESET_INTERVAL_TYP_NS = 600;
   localparam int POWERUP_RESET_INTERVAL_MAX_NS = 1000;
   localparam int IN_OFF_NS  = SLOW_GRADE ? 15 : 10;
   localparam int IN_ON_NS   = SLOW_GRADE ? 15 : 10;
   localparam int CTL_ON_NS  = SLOW_GRADE ? 30 : 25;
   localparam int OUT_ON_NS  = SLOW_GRADE ? 35 : 30;

   // longest times round down, never below one cycle
   function automatic int floor_cyc(input int ns);
      floor_cyc = (ns / CLK_PERIOD_NS < 1) ? 1 : ns / CLK_PERIOD_NS;
   endfunction

   localparam logic [CNT_W-1:0] PWRUP_CYC  = CNT_W'(floor_cyc(POWERUP_RESET_INTERVAL_MAX_NS));
   localparam logic [CNT_W-1:0] IN_OFF_CYC = CNT_W'(floor_cyc(IN_OFF_NS));
   localparam logic [CNT_W-1:0] IN_ON_CYC  = CNT_W'(floor_cyc(IN_ON_NS));
   localparam logic [CNT_W-1:0] CTL_ON_CYC = CNT_W'(floor_cyc(CTL_ON_NS));
   localparam logic [CNT_W-1:0] OUT_ON_CYC = CNT_W'(floor_cyc(OUT_ON_NS));
   localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;
   localparam logic [CNT_W-1:0] CNT_MAX    = 8'hFF;

   // register byte offsets
   localparam logic [5:0] REG_CONFIG   = 6'h00;
   localparam logic [5:0] REG_POLARITY = 6'h04;
   localparam logic [5:0] REG_PRELOAD  = 6'h08;
   localparam logic [5:0] REG_SECURE   = 6'h0C;
   localparam logic [5:0] REG_STATUS   = 6'h10;
   localparam logic [5:0] REG_MACSTATE = 6'h14;
   localparam logic [5:0] REG_SIG_LO   = 6'h18;
   localparam logic [5:0] REG_SIG_HI   = 6'h1C;

   // field positions
   localparam int CFG_PD_EN_BIT      = 0;
   localparam int SECURE_SET_BIT     = 0;
   localparam int PRELOAD_MASK_LSB   = 16;
   localparam int ST_SECURED_BIT     = 0;
   localparam int ST_DOWN_BIT        = 1;
   localparam int ST_PWRUP_DONE_BIT  = 2;
   localparam int ST_RB_REFUSED_BIT  = 3;
   localparam int ST_PL_REFUSED_BIT  = 4;

   // reset values; signature defaults are arbitrary
   localparam logic [MAC_W-1:0] POLARITY_RST = 10'h000;
   localparam logic [SIG_W-1:0] SIG_LO_RST   = 32'h00000000;
   localparam logic [SIG_W-1:0] SIG_HI_RST   = 32'h00000000;

   typedef enum logic [1:0] {
      PD_ACTIVE = 2'h0,
      PD_DOWN   = 2'h1,
      PD_WAKE   = 2'h2
   } pd_state_t;

endpackage

// [hw/sample_hold.sv]
// register that samples its input while enabled and holds it otherwise
module sample_hold #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   // data
   input  wire logic         en_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] q_d;

   always_comb begin
      q_d = en_in ? d_in : q_out;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q_out <= '0;
      end else begin
         q_out <= q_d;
      end
   end

endmodule

// [hw/pd_sequencer.sv]
// power-down entry and staged wake-up sequencing
module pd_sequencer (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // power-down request
   input  wire logic pd_active_in,
   // gates
   output logic      in_accept_out,
   output logic      ctl_accept_out,
   output logic      out_valid_out,
   output logic      down_out
);

   plc_pkg::pd_state_t              state_q, state_d;
   logic [plc_pkg::CNT_W-1:0]       cnt_q, cnt_d;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         plc_pkg::PD_ACTIVE: begin
            if (pd_active_in) begin
               state_d = plc_pkg::PD_DOWN;
            end
         end
         plc_pkg::PD_DOWN: begin
            if (!pd_active_in) begin
               state_d = plc_pkg::PD_WAKE;
               cnt_d   = plc_pkg::CNT_ONE;
            end
         end
         plc_pkg::PD_WAKE: begin
            if (pd_active_in) begin
               state_d = plc_pkg::PD_DOWN;
            end else if (cnt_q >= plc_pkg::OUT_ON_CYC) begin
               state_d = plc_pkg::PD_ACTIVE;
            end else begin
               cnt_d = cnt_q + plc_pkg::CNT_ONE;
            end
         end
         default: begin
            state_d = plc_pkg::PD_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q <= plc_pkg::PD_ACTIVE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // each class of pin comes back at its own delay after the pin falls
   assign in_accept_out  = (state_q == plc_pkg::PD_ACTIVE) ||
                           ((state_q == plc_pkg::PD_WAKE) && (cnt_q >= plc_pkg::IN_ON_CYC));
   assign ctl_accept_out = (state_q == plc_pkg::PD_ACTIVE) ||
                           ((state_q == plc_pkg::PD_WAKE) && (cnt_q >= plc_pkg::CTL_ON_CYC));
   assign out_valid_out  = (state_q == plc_pkg::PD_ACTIVE) ||
                           ((state_q == plc_pkg::PD_WAKE) && (cnt_q >= plc_pkg::OUT_ON_CYC));
   assign down_out       = (state_q == plc_pkg::PD_DOWN);

endmodule

// [hw/logic_array_power_reset_control.sv]
// macrocell registers with power-up clear, power-down hold, preload and security
// Functional notes
// - power-up clears all macrocell registers low without a clock edge
// - after clear each output pin shows register value through its polarity
// - preload forces each register individually high or low
// - 64 signature bits stay readable at all times, secured or not
// - security bit refuses readback and preload, still allows signature reads
// - inputs, enable and clock ignored within 10 or 15 ns of power-down
// - logic inputs accepted again within 10 or 15 ns of power-down falling
// - enable and clock accepted again within 25 or 30 ns after falling
// - outputs valid again within 30 or 35 ns after power-down falls
// - in power-down all registers, outputs and states are held
// - in power-down every input except the power-down pin is blocked
// - with power-down option off the shared pin is an array input
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
module logic_array_power_reset_control (
   // clock and reset
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   // avalon-mm slave
   input  wire logic [5:0]                 avs_address_in,
   input  wire logic                       avs_read_in,
   input  wire logic                       avs_write_in,
   input  wire logic [31:0]                avs_writedata_in,
   output logic      [31:0]                avs_readdata_out,
   output logic                            avs_waitrequest_out,
   // device pins
   input  wire logic [plc_pkg::IN_W-1:0]   logic_in,
   input  wire logic                       power_down_pin_in,
   input  wire logic                       dev_clk_in,
   input  wire logic                       oe_in,
   input  wire logic                       async_reset_in,
   input  wire logic                       sync_preset_in,
   input  wire logic [plc_pkg::MAC_W-1:0]  array_next_in,
   // array side
   output logic      [plc_pkg::ARR_W-1:0]  array_in_out,
   output logic      [plc_pkg::MAC_W-1:0]  pin_out,
   output logic      [plc_pkg::MAC_W-1:0]  pin_oe_out,
   output logic                            powered_down_out
);

   // configuration and status
   logic                        pd_en_q, pd_en_d;
   logic [plc_pkg::MAC_W-1:0]   pol_q, pol_d;
   logic [plc_pkg::SIG_W-1:0]   sig_lo_q, sig_lo_d;
   logic [plc_pkg::SIG_W-1:0]   sig_hi_q, sig_hi_d;
   logic                        secured_q, secured_d;
   logic                        rb_ref_q, rb_ref_d;
   logic                        pl_ref_q, pl_ref_d;
   logic [31:0]                 rdata_d;
   logic                        wait_d;
   // macrocells and pins
   logic [plc_pkg::MAC_W-1:0]   mac_q, mac_d;
   logic [plc_pkg::MAC_W-1:0]   pin_d, oe_d;
   logic                        clk_prev_q, clk_prev_d;
   logic [plc_pkg::CNT_W-1:0]   pwrup_cnt_q, pwrup_cnt_d;
   logic                        pwrup_done_q, pwrup_done_d;
   logic                        down_d;
   // wires
   logic                        pd_active;
   logic                        in_accept, ctl_accept, out_valid, seq_down;
   logic [plc_pkg::CTL_W-1:0]   ctl_h;
   logic                        oe_h, clk_h, arst_h, spre_h;
   logic                        wr_acc, rd_start, clk_rise, preload_ok;
   logic [plc_pkg::MAC_W-1:0]   pl_val, pl_mask;

   function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
      hit = (addr == off);
   endfunction

   // the shared pin only means power-down when the option is configured
   assign pd_active = pd_en_q & power_down_pin_in;

   pd_sequencer u_seq (
      .clk_in         (clk_in),
      .rst_in         (rst_in),
      .pd_active_in   (pd_active),
      .in_accept_out  (in_accept),
      .ctl_accept_out (ctl_accept),
      .out_valid_out  (out_valid),
      .down_out       (seq_down)
   );

   // inputs freeze at their last accepted level while blocked
   sample_hold #(.W(plc_pkg::ARR_W)) u_in_hold (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .en_in  (in_accept),
      .d_in   ({(pd_en_q ? 1'b0 : power_down_pin_in), logic_in}),
      .q_out  (array_in_out)
   );

   sample_hold #(.W(plc_pkg::CTL_W)) u_ctl_hold (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .en_in  (ctl_accept),
      .d_in   ({oe_in, dev_clk_in, async_reset_in, sync_preset_in}),
      .q_out  (ctl_h)
   );

   assign {oe_h, clk_h, arst_h, spre_h} = ctl_h;

   assign wr_acc   = avs_write_in & ~avs_waitrequest_out;
   assign rd_start = avs_read_in & avs_waitrequest_out;
   assign pl_val   = avs_writedata_in[plc_pkg::MAC_W-1:0];
   assign pl_mask  = avs_writedata_in[plc_pkg::PRELOAD_MASK_LSB +: plc_pkg::MAC_W];
   assign preload_ok = wr_acc & hit(avs_address_in, plc_pkg::REG_PRELOAD) &
                       ~secured_q & ~seq_down;
   // the clock is ignored until the power-up interval has run out
   assign clk_rise = clk_h & ~clk_prev_q & ctl_accept & pwrup_done_q;

   // power-up interval and macrocells
   always_comb begin
      pwrup_cnt_d  = pwrup_cnt_q;
      pwrup_done_d = pwrup_done_q;
      if (!pwrup_done_q) begin
         pwrup_cnt_d  = pwrup_cnt_q + plc_pkg::CNT_ONE;
         pwrup_done_d = (pwrup_cnt_d >= plc_pkg::PWRUP_CYC);
      end
      clk_prev_d = clk_h;
      mac_d      = mac_q;
      if (ctl_accept && arst_h) begin
         mac_d = '0;
      end else if (preload_ok) begin
         mac_d = (mac_q & ~pl_mask) | (pl_val & pl_mask);
      end else if (clk_rise) begin
         mac_d = spre_h ? '1 : array_next_in;
      end
      // outputs and enables freeze until the wake sequence releases them
      pin_d  = out_valid ? (mac_q ^ pol_q) : pin_out;
      oe_d   = out_valid ? {plc_pkg::MAC_W{oe_h}} : pin_oe_out;
      down_d = seq_down;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mac_q            <= '0;
         pin_out          <= '0;
         pin_oe_out       <= '0;
         clk_prev_q       <= 1'b0;
         pwrup_cnt_q      <= '0;
         pwrup_done_q     <= 1'b0;
         powered_down_out <= 1'b0;
      end else begin
         mac_q            <= mac_d;
         pin_out          <= pin_d;
         pin_oe_out       <= oe_d;
         clk_prev_q       <= clk_prev_d;
         pwrup_cnt_q      <= pwrup_cnt_d;
         pwrup_done_q     <= pwrup_done_d;
         powered_down_out <= down_d;
      end
   end

   // register file: answer one cycle after the request, take writes on release
   always_comb begin
      pd_en_d   = pd_en_q;
      pol_d     = pol_q;
      sig_lo_d  = sig_lo_q;
      sig_hi_d  = sig_hi_q;
      secured_d = secured_q;
      rb_ref_d  = rb_ref_q;
      pl_ref_d  = pl_ref_q;
      rdata_d   = avs_readdata_out;
      wait_d    = ~((avs_read_in | avs_write_in) & avs_waitrequest_out);
      if (wr_acc) begin
         if (hit(avs_address_in, plc_pkg::REG_CONFIG)) begin
            pd_en_d = avs_writedata_in[plc_pkg::CFG_PD_EN_BIT];
         end else if (hit(avs_address_in, plc_pkg::REG_POLARITY)) begin
            pol_d = avs_writedata_in[plc_pkg::MAC_W-1:0];
         end else if (hit(avs_address_in, plc_pkg::REG_SECURE)) begin
            // the lock is immediate and stays until the next power-up
            secured_d = secured_q | avs_writedata_in[plc_pkg::SECURE_SET_BIT];
         end else if (hit(avs_address_in, plc_pkg::REG_STATUS)) begin
            rb_ref_d = rb_ref_q & ~avs_writedata_in[plc_pkg::ST_RB_REFUSED_BIT];
            pl_ref_d = pl_ref_q & ~avs_writedata_in[plc_pkg::ST_PL_REFUSED_BIT];
         end else if (hit(avs_address_in, plc_pkg::REG_SIG_LO) && !secured_q) begin
            sig_lo_d = avs_writedata_in;
         end else if (hit(avs_address_in, plc_pkg::REG_SIG_HI) && !secured_q) begin
            sig_hi_d = avs_writedata_in;
         end
      end
      // set wins over a clear in the same cycle
      if (wr_acc && hit(avs_address_in, plc_pkg::REG_PRELOAD) && secured_q) begin
         pl_ref_d = 1'b1;
      end
      if (rd_start) begin
         rdata_d = 32'h00000000;
         if (hit(avs_address_in, plc_pkg::REG_CONFIG)) begin
            rdata_d[plc_pkg::CFG_PD_EN_BIT] = pd_en_q & ~secured_q;
            rb_ref_d = rb_ref_d | secured_q;
         end else if (hit(avs_address_in, plc_pkg::REG_POLARITY)) begin
            rdata_d[plc_pkg::MAC_W-1:0] = secured_q ? '0 : pol_q;
            rb_ref_d = rb_ref_d | secured_q;
         end else if (hit(avs_address_in, plc_pkg::REG_MACSTATE)) begin
            rdata_d[plc_pkg::MAC_W-1:0] = secured_q ? '0 : mac_q;
            rb_ref_d = rb_ref_d | secured_q;
         end else if (hit(avs_address_in, plc_pkg::REG_STATUS)) begin
            rdata_d[plc_pkg::ST_SECURED_BIT]    = secured_q;
            rdata_d[plc_pkg::ST_DOWN_BIT]       = seq_down;
            rdata_d[plc_pkg::ST_PWRUP_DONE_BIT] = pwrup_done_q;
            rdata_d[plc_pkg::ST_RB_REFUSED_BIT] = rb_ref_q;
            rdata_d[plc_pkg::ST_PL_REFUSED_BIT] = pl_ref_q;
         end else if (hit(avs_address_in, plc_pkg::REG_SIG_LO)) begin
            rdata_d = sig_lo_q;
         end else if (hit(avs_address_in, plc_pkg::REG_SIG_HI)) begin
            rdata_d = sig_hi_q;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pd_en_q             <= 1'b0;
         pol_q               <= plc_pkg::POLARITY_RST;
         sig_lo_q            <= plc_pkg::SIG_LO_RST;
         sig_hi_q            <= plc_pkg::SIG_HI_RST;
         secured_q           <= 1'b0;
         rb_ref_q            <= 1'b0;
         pl_ref_q            <= 1'b0;
         avs_readdata_out    <= 32'h00000000;
         avs_waitrequest_out <= 1'b1;
      end else begin
         pd_en_q             <= pd_en_d;
         pol_q               <= pol_d;
         sig_lo_q            <= sig_lo_d;
         sig_hi_q            <= sig_hi_d;
         secured_q           <= secured_d;
         rb_ref_q            <= rb_ref_d;
         pl_ref_q            <= pl_ref_d;
         avs_readdata_out    <= rdata_d;
         avs_waitrequest_out <= wait_d;
      end
   end

   // helper: cycles since the power-down request was last seen high
   logic [plc_pkg::CNT_W-1:0] quiet_q;

   always_ff @(posedge clk_in) begin
      if (rst_in || pd_active) begin
         quiet_q <= '0;
      end else if (quiet_q != plc_pkg::CNT_MAX) begin
         quiet_q <= quiet_q + plc_pkg::CNT_ONE;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_preload_req;
      avs_write_in && !avs_waitrequest_out && avs_address_in == plc_pkg::REG_PRELOAD;
   endsequence

   sequence s_free_preload;
      s_preload_req ##0 (!secured_q && !seq_down && !(ctl_accept && arst_h));
   endsequence

   a_powerup_clear: assert property ($past(rst_in) |-> mac_q == '0)
      else $error("macrocells not cleared after power-up");

   a_pin_polarity: assert property (
      $past(out_valid) |-> pin_out == ($past(mac_q) ^ $past(pol_q)))
      else $error("pin level does not follow register and polarity");

   a_preload_force: assert property (
      s_free_preload |=> mac_q == (($past(mac_q) & ~$past(pl_mask)) |
                                   ($past(pl_val) & $past(pl_mask))))
      else $error("preload did not force the selected registers");

   a_sig_readable: assert property (
      (rd_start && avs_address_in == plc_pkg::REG_SIG_HI)
      |=> !avs_waitrequest_out && avs_readdata_out == $past(sig_hi_q))
      else $error("signature read returned wrong data");

   // a clock rise or async reset in the same cycle may still move the registers
   a_secure_refuse: assert property (
      (s_preload_req and (secured_q && !clk_rise && !(ctl_accept && arst_h)))
      |=> $stable(mac_q) && pl_ref_q)
      else $error("preload not refused while secured");

   a_pd_block: assert property (
      pd_active |=> !in_accept && !ctl_accept)
      else $error("inputs still accepted after power-down request");

   a_wake_stage: assert property (
      (quiet_q >= plc_pkg::IN_ON_CYC) |-> in_accept)
      else $error("logic inputs not released in time after power-down");

   a_wake_ctl: assert property (
      (quiet_q >= plc_pkg::CTL_ON_CYC) |-> ctl_accept && !seq_down)
      else $error("enable and clock not released in time");

   a_wake_out: assert property (
      (quiet_q >= plc_pkg::OUT_ON_CYC) |-> out_valid)
      else $error("outputs not valid in time after power-down");

   a_pd_hold: assert property (
      (seq_down && $past(seq_down)) |-> $stable(mac_q) && $stable(pin_out) &&
                                        $stable(pin_oe_out))
      else $error("state changed during power-down");

   a_shared_pin: assert property (
      !pd_en_q && in_accept |=> array_in_out[plc_pkg::IN_W] == $past(power_down_pin_in))
      else $error("shared pin not passed to the array");

endmodule

// [tb/board_model.sv]
// board-side driver of the device pins: inputs, device clock, enable, power-down
module board_model (
   // clock
   input  wire logic                      clk_in,
   // device pins
   output logic      [plc_pkg::IN_W-1:0]  logic_out,
   output logic                           pd_pin_out,
   output logic                           dev_clk_out,
   output logic                           oe_out,
   output logic                           areset_out,
   output logic                           spreset_out,
   output logic      [plc_pkg::MAC_W-1:0] next_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // device clock rests low between ticks, so it is steady through power-up
   initial begin
      {logic_out, pd_pin_out, dev_clk_out, oe_out, areset_out, spreset_out} = '0;
      next_out = '0;
   end

   // one device clock rise; next value and preset lead it by three cycles
   task automatic tick(input logic [9:0] nxt, input logic pre);
      @(posedge clk_in);
      next_out    <= nxt;
      spreset_out <= pre;
      repeat (3) @(posedge clk_in);
      dev_clk_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      dev_clk_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      // hold has run out: the next-value lines stop showing the old word
      next_out    <= ~nxt;
      spreset_out <= 1'b0;
   endtask

   task automatic areset();
      @(posedge clk_in);
      areset_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      areset_out <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask

   // inputs settle 12 ns before the power-down pin moves
   task automatic pd_set(input logic lvl, input logic [10:0] lin, input logic oe);
      @(posedge clk_in);
      logic_out <= lin;
      oe_out    <= oe;
      repeat (3) @(posedge clk_in);
      pd_pin_out <= lvl;
   endtask

   task automatic set_in(input logic [10:0] lin, input logic oe);
      @(posedge clk_in);
      logic_out <= lin;
      oe_out    <= oe;
   endtask
endmodule

// [tb/logic_array_power_reset_control_test.sv]
// self-checking bench for the logic array power and reset control block
module logic_array_power_reset_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in, rst_in, avs_read, avs_write, avs_wait, dclk, oe, ar, sp, pd, pdown;
   logic [5:0]  avs_addr;
   logic [31:0] avs_wdata, avs_rdata, v, r;
   logic [10:0] lin;
   logic [11:0] arr;
   logic [9:0]  nxt, pin, pin_oe;
   int          error_cnt, tests_run, mac, pol, n;
   int          sig_q[$];
   integer      seed;

   logic_array_power_reset_control dut (
      .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_addr),
      .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_wdata),
      .avs_readdata_out(avs_rdata), .avs_waitrequest_out(avs_wait),
      .logic_in(lin), .power_down_pin_in(pd), .dev_clk_in(dclk), .oe_in(oe),
      .async_reset_in(ar), .sync_preset_in(sp), .array_next_in(nxt),
      .array_in_out(arr), .pin_out(pin), .pin_oe_out(pin_oe), .powered_down_out(pdown)
   );
   board_model board (
      .clk_in(clk_in), .logic_out(lin), .pd_pin_out(pd), .dev_clk_out(dclk), .oe_out(oe),
      .areset_out(ar), .spreset_out(sp), .next_out(nxt)
   );

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   initial begin
      repeat (100000) @(posedge clk_in);
      error_cnt++;
      end_of_test();
   end

   task automatic end_of_test();
      $display("compared %0d, mismatched %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one avalon transfer; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_in);
      avs_addr  <= a;
      avs_wdata <= d;
      avs_write <= w;
      avs_read  <= ~w;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_wait !== 1'b0 && n < 20);
      q = avs_rdata;
      if (n >= 20) begin
         error_cnt++;
         end_of_test();
      end
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d, r);
   endtask

   task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask

   task automatic pins();
      chk(32'(pin), 32'(mac ^ pol));
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   initial begin
      seed = 32'h641eea70;
      {mac, pol, error_cnt, tests_run} = '0;
      {avs_read, avs_write, avs_addr, avs_wdata} = '0;
      rst_in = 1'b1;
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      chk(32'(pin), 32'h0);
      chk(32'(pin_oe), 32'h0);
      // no device clock until the power-up interval has run out
      repeat (260) @(posedge clk_in);
      v = $random(seed);
      pol = int'(v[9:0]);
      wr(plc_pkg::REG_POLARITY, 32'(v[9:0]));
      rdchk(plc_pkg::REG_MACSTATE, 32'h0);
      rdchk(plc_pkg::REG_STATUS, 32'h4);
      pins();
      done("power-up");
      board.set_in(11'h0, 1'b1);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         board.tick(v[9:0], 1'b0);
         mac = int'(v[9:0]);
         pins();
      end
      chk(32'(pin_oe), 32'h3FF);
      board.tick(10'h0, 1'b1);
      mac = 'h3FF;
      pins();
      board.areset();
      mac = 0;
      pins();
      for (int i = 0; i < 3; i++) begin
         v = $random(seed) & 32'h03FF03FF;
         wr(plc_pkg::REG_PRELOAD, v);
         mac = (mac & ~int'(v[25:16])) | int'(v[9:0] & v[25:16]);
         rdchk(plc_pkg::REG_MACSTATE, 32'(mac));
         pins();
      end
      done("clock and preload");
      v = $random(seed);
      board.pd_set(1'b1, v[10:0], 1'b1);
      repeat (4) @(posedge clk_in);
      chk(32'(arr), 32'({1'b1, v[10:0]}));
      chk(32'(pdown), 32'h0);
      board.pd_set(1'b0, v[10:0], 1'b1);
      done("shared pin as input");
      wr(plc_pkg::REG_CONFIG, 32'h1);
      v = $random(seed);
      board.pd_set(1'b1, v[10:0], 1'b1);
      repeat (3) @(posedge clk_in);
      chk(32'(pdown), 32'h1);
      chk(32'(arr), 32'(v[10:0]));
      // everything but the power-down pin moves and must be ignored
      board.set_in(~v[10:0], 1'b0);
      board.tick(~pin, 1'b1);
      board.areset();
      wr(plc_pkg::REG_PRELOAD, 32'h03FF0000 | 32'(~mac & 'h3FF));
      rdchk(plc_pkg::REG_MACSTATE, 32'(mac));
      chk(32'(arr), 32'(v[10:0]));
      chk(32'(pin_oe), 32'h3FF);
      pins();
      v = $random(seed);
      board.pd_set(1'b0, v[10:0], 1'b0);
      for (n = 0; n < 5 && arr !== 12'(v[10:0]); n++)
         @(posedge clk_in);
      chk(32'(arr), 32'(v[10:0]));
      for (n = 0; n < 8 && pin_oe !== 10'h0; n++)
         @(posedge clk_in);
      chk(32'(pin_oe), 32'h0);
      repeat (3) @(posedge clk_in);
      pins();
      chk(32'(pdown), 32'h0);
      rdchk(plc_pkg::REG_MACSTATE, 32'(mac));
      v = $random(seed);
      board.tick(v[9:0], 1'b0);
      mac = int'(v[9:0]);
      pins();
      done("power-down");
      for (int i = 0; i < 2; i++) begin
         sig_q.push_back(int'($random(seed)));
         wr(i ? plc_pkg::REG_SIG_HI : plc_pkg::REG_SIG_LO, 32'(sig_q[i]));
      end
      // the lock goes in last since it takes hold at once
      wr(plc_pkg::REG_SECURE, 32'h1);
      rdchk(plc_pkg::REG_SIG_LO, 32'(sig_q[0]));
      rdchk(plc_pkg::REG_SIG_HI, 32'(sig_q[1]));
      rdchk(plc_pkg::REG_MACSTATE, 32'h0);
      rdchk(plc_pkg::REG_STATUS, 32'hD);
      wr(plc_pkg::REG_PRELOAD, 32'h03FF0000 | 32'(~mac & 'h3FF));
      rdchk(plc_pkg::REG_STATUS, 32'h1D);
      pins();
      wr(plc_pkg::REG_SIG_LO, ~32'(sig_q[0]));
      rdchk(plc_pkg::REG_SIG_LO, 32'(sig_q[0]));
      wr(6'h3C, 32'hFFFFFFFF);
      rdchk(6'h20, 32'h0);
      done("security");
      rst_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      chk(32'(pin), 32'h0);
      rdchk(plc_pkg::REG_STATUS, 32'h0);
      done("second reset");
      end_of_test();
   end
endmodule
